// ==== common/pps_defs.svh ====
// register map, field positions and reset values of the port-0 phy poll status block
// Functional notes
// - Receive data valid sets the receive-activity flag at bit 10; writing one to it clears it.
// - Transmit enable sets the transmit-activity flag at bit 9; writing one to it clears it.
// - Bit 8 reads one when the polled phy can stop its transmit clock, else zero.
// - Bit 7 reads one when phy and partner support energy saving at the current speed.
// - Bit 6 reads one while the phy answers management polling, zero when it is silent.
// - Bit 5 shows the polled link state, one for up and zero for down.
// - Bits 4:3 show the polled speed: 00 10M, 01 100M, 10 1G or more, 11 reserved.
// - Bit 2 shows the polled duplex mode, one for full and zero for half.
// - Bit 1 reads one when polling shows the partner sends pause frames.
// - Bit 0 reads one when polling shows the partner honours pause frames.
// - The hardware status fields in bits 8:0 come only from polling results, never from software writes.
// - With autopolling disabled the link parameters come from the override register.
// - Polling addresses the phy with the 5-bit address held in override bits 4:0.
`ifndef PPS_DEFS_SVH
`define PPS_DEFS_SVH

// register indices; byte address is four times the index
`define PPS_IDX_CFG      8'h10
`define PPS_IDX_OVR      8'h15
`define PPS_IDX_STAT     8'h16
`define PPS_IDX_IRQ_STAT 8'h18
`define PPS_IDX_IRQ_EN   8'h19
`define PPS_IDX_IRQ_CLR  8'h1A
`define PPS_IDX_LINK     8'h1B

`define PPS_RST_OVR      16'h1800
`define PPS_RST_CFG      1'h1
`define PPS_RST_IRQ_EN   4'h0

// status register fields
`define PPS_STAT_RX      10
`define PPS_STAT_TX      9

// override register fields
`define PPS_OVR_AUTO_SEL 15
`define PPS_OVR_LINK_HI  14
`define PPS_OVR_SPD_HI   12
`define PPS_OVR_DUP_HI   10
`define PPS_OVR_FCTX_HI  8
`define PPS_OVR_FCRX_HI  6
`define PPS_OVR_ADDR_HI  4

// event bits of the interrupt registers
`define PPS_EV_RX        0
`define PPS_EV_TX        1
`define PPS_EV_LINK      2
`define PPS_EV_RESP      3

`endif

// ==== common/pps_pkg.sv ====
// types shared by the phy poll status block
package pps_pkg;

	// one result of a successful poll of the attached phy
	typedef struct packed {
		logic       clk_halt;
		logic       energy_saving;
		logic       link_up;
		logic [1:0] speed;
		logic       full_duplex;
		logic       sends_pause;
		logic       honours_pause;
	} pps_poll_res_t;

	// resolved link parameters handed to the mac
	typedef struct packed {
		logic       link_up;
		logic [1:0] speed;
		logic       full_duplex;
		logic       fc_rx;
		logic       fc_tx;
	} pps_link_t;

	typedef enum logic [1:0] {
		PPS_BUS_IDLE = 2'b01,
		PPS_BUS_RESP = 2'b10
	} pps_bus_st_t;

endpackage

// ==== hw/pps_poll_status.sv ====
// port-0 phy poll status register with override, interrupts and apb slave
`timescale 1ns/100ps
`include "pps_defs.svh"

module pps_poll_status
	import pps_pkg::*;
(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          pce,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [11:0]   paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire logic          poll_upd,
	input  wire logic          poll_noresp,
	input  wire pps_poll_res_t poll_res,
	input  wire pps_link_t     gphy_link,
	input  wire logic          mii_rxdv,
	input  wire logic          mii_txen,
	output pps_link_t          link_out,
	output logic      [4:0]    phy_addr,
	output logic               autopoll_en,
	output logic               irq
);

	// resolve a two-bit force code: 01 forces one, 11 forces zero, else the automatic value
	function automatic logic pick_flag(input logic [1:0] code, input logic auto_val);
		logic r;
		r = auto_val;
		if (code == 2'b01) begin
			r = 1'b1;
		end else if (code == 2'b11) begin
			r = 1'b0;
		end
		return r;
	endfunction

	// link control uses 01 up, 10 down
	function automatic logic pick_link(input logic [1:0] code, input logic auto_val);
		logic r;
		r = auto_val;
		if (code == 2'b01) begin
			r = 1'b1;
		end else if (code == 2'b10) begin
			r = 1'b0;
		end
		return r;
	endfunction

	function automatic logic reg_hit(input logic [11:0] a, input logic [7:0] idx);
		return a == {2'h0, idx, 2'h0};
	endfunction

	// apb slave state
	pps_bus_st_t bus_st_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] prdata_q;

	// mii activity synchronisers
	logic rxdv_m_q;
	logic rxdv_s_q;
	logic txen_m_q;
	logic txen_s_q;

	// status fields
	logic       rx_traffic_seen_q;
	logic       tx_traffic_seen_q;
	logic       tx_clock_halt_supported_q;
	logic       energy_saving_supported_q;
	logic       phy_responding_q;
	logic       link_up_state_q;
	logic [1:0] speed_q;
	logic       full_duplex_state_q;
	logic       partner_sends_pause_q;
	logic       partner_honours_pause_q;

	// software registers
	logic [15:0] port0_link_override_reg_q;
	logic        poll_config_reg_q;
	logic [3:0]  irq_stat_q;
	logic [3:0]  irq_en_q;
	logic        irq_q;
	pps_link_t   link_q;

	// bus decode
	wire bus_req  = psel & penable & (bus_st_q == PPS_BUS_IDLE);
	wire bus_done = psel & penable & (bus_st_q == PPS_BUS_RESP);
	wire wr_done  = bus_done & pwrite;
	wire hit_cfg  = reg_hit(paddr, `PPS_IDX_CFG);
	wire hit_ovr  = reg_hit(paddr, `PPS_IDX_OVR);
	wire hit_stat = reg_hit(paddr, `PPS_IDX_STAT);
	wire hit_ist  = reg_hit(paddr, `PPS_IDX_IRQ_STAT);
	wire hit_ien  = reg_hit(paddr, `PPS_IDX_IRQ_EN);
	wire hit_iclr = reg_hit(paddr, `PPS_IDX_IRQ_CLR);
	wire hit_link = reg_hit(paddr, `PPS_IDX_LINK);
	wire hit_any  = hit_cfg | hit_ovr | hit_stat | hit_ist | hit_ien | hit_iclr | hit_link;

	wire wr_cfg  = wr_done & hit_cfg;
	wire wr_ovr  = wr_done & hit_ovr;
	wire wr_stat = wr_done & hit_stat;
	wire wr_ien  = wr_done & hit_ien;
	wire wr_iclr = wr_done & hit_iclr;

	// write-one-to-clear of the activity flags; a set in the same cycle wins
	wire rx_clr = wr_stat & pwdata[`PPS_STAT_RX];
	wire tx_clr = wr_stat & pwdata[`PPS_STAT_TX];
	wire rx_set = rxdv_s_q;
	wire tx_set = txen_s_q;

	// status word; bits 15:11 are not stored and read zero
	wire [15:0] stat_word = {
		5'h00,
		rx_traffic_seen_q,
		tx_traffic_seen_q,
		tx_clock_halt_supported_q,
		energy_saving_supported_q,
		phy_responding_q,
		link_up_state_q,
		speed_q,
		full_duplex_state_q,
		partner_sends_pause_q,
		partner_honours_pause_q
	};

	// override fields
	wire       ovr_auto_sel = port0_link_override_reg_q[`PPS_OVR_AUTO_SEL];
	wire [1:0] ovr_link     = port0_link_override_reg_q[`PPS_OVR_LINK_HI -: 2];
	wire [1:0] ovr_speed    = port0_link_override_reg_q[`PPS_OVR_SPD_HI -: 2];
	wire [1:0] ovr_duplex   = port0_link_override_reg_q[`PPS_OVR_DUP_HI -: 2];
	wire [1:0] ovr_fc_tx    = port0_link_override_reg_q[`PPS_OVR_FCTX_HI -: 2];
	wire [1:0] ovr_fc_rx    = port0_link_override_reg_q[`PPS_OVR_FCRX_HI -: 2];

	// link parameters as the polling engine last saw them
	pps_link_t polled_link;
	assign polled_link.link_up     = link_up_state_q;
	assign polled_link.speed       = speed_q;
	assign polled_link.full_duplex = full_duplex_state_q;
	assign polled_link.fc_rx       = partner_sends_pause_q;
	assign polled_link.fc_tx       = partner_honours_pause_q;

	// automatic source in override mode: polling results or the integrated phy outputs
	wire pps_link_t auto_link = ovr_auto_sel ? gphy_link : polled_link;

	pps_link_t forced_link;
	assign forced_link.link_up     = pick_link(ovr_link, auto_link.link_up);
	assign forced_link.speed       = (ovr_speed == 2'b11) ? auto_link.speed : ovr_speed;
	assign forced_link.full_duplex = pick_flag(ovr_duplex, auto_link.full_duplex);
	assign forced_link.fc_rx       = pick_flag(ovr_fc_rx, auto_link.fc_rx);
	assign forced_link.fc_tx       = pick_flag(ovr_fc_tx, auto_link.fc_tx);

	wire pps_link_t link_d = poll_config_reg_q ? polled_link : forced_link;

	// interrupt events
	wire resp_edge = (poll_upd & ~phy_responding_q) | (~poll_upd & poll_noresp & phy_responding_q);
	wire link_edge = (poll_upd & (poll_res.link_up != link_up_state_q))
		| (~poll_upd & poll_noresp & link_up_state_q);

	wire [3:0] ev;
	assign ev[`PPS_EV_RX]   = rx_set;
	assign ev[`PPS_EV_TX]   = tx_set;
	assign ev[`PPS_EV_LINK] = link_edge;
	assign ev[`PPS_EV_RESP] = resp_edge;

	wire [3:0] iclr_bits  = wr_iclr ? pwdata[3:0] : 4'h0;
	wire [3:0] irq_stat_d = (irq_stat_q & ~iclr_bits) | ev;
	wire       irq_d      = |(irq_stat_d & irq_en_q);

	// read mux
	wire [31:0] rdata =
		hit_cfg  ? {31'h0, poll_config_reg_q} :
		hit_ovr  ? {16'h0, port0_link_override_reg_q} :
		hit_stat ? {16'h0, stat_word} :
		hit_ist  ? {28'h0, irq_stat_q} :
		hit_ien  ? {28'h0, irq_en_q} :
		hit_link ? {26'h0, link_q} :
		32'h0;

	// apb: one wait state, answer registered so outputs come from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_st_q  <= PPS_BUS_IDLE;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0;
		end else if (pce) begin
			unique case (bus_st_q)
				PPS_BUS_IDLE: begin
					if (bus_req) begin
						bus_st_q  <= PPS_BUS_RESP;
						pready_q  <= 1'b1;
						pslverr_q <= ~hit_any;
						prdata_q  <= pwrite ? 32'h0 : rdata;
					end
				end
				PPS_BUS_RESP: begin
					bus_st_q  <= PPS_BUS_IDLE;
					pready_q  <= 1'b0;
					pslverr_q <= 1'b0;
				end
				default: begin
					bus_st_q <= PPS_BUS_IDLE;
					pready_q <= 1'b0;
				end
			endcase
		end
	end

	// mii enables come from the line clock; two flops before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxdv_m_q <= 1'b0;
			rxdv_s_q <= 1'b0;
			txen_m_q <= 1'b0;
			txen_s_q <= 1'b0;
		end else if (pce) begin
			rxdv_m_q <= mii_rxdv;
			rxdv_s_q <= rxdv_m_q;
			txen_m_q <= mii_txen;
			txen_s_q <= txen_m_q;
		end
	end

	// sticky activity flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_traffic_seen_q <= 1'b0;
			tx_traffic_seen_q <= 1'b0;
		end else if (pce) begin
			rx_traffic_seen_q <= rx_set | (rx_traffic_seen_q & ~rx_clr);
			tx_traffic_seen_q <= tx_set | (tx_traffic_seen_q & ~tx_clr);
		end
	end

	// polled fields: loaded only from the polling engine, software writes never reach them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_clock_halt_supported_q <= 1'b0;
			energy_saving_supported_q <= 1'b0;
			link_up_state_q           <= 1'b0;
			speed_q                   <= 2'h0;
			full_duplex_state_q       <= 1'b0;
			partner_sends_pause_q     <= 1'b0;
			partner_honours_pause_q   <= 1'b0;
		end else if (pce && poll_upd) begin
			tx_clock_halt_supported_q <= poll_res.clk_halt;
			energy_saving_supported_q <= poll_res.energy_saving;
			link_up_state_q           <= poll_res.link_up;
			speed_q                   <= poll_res.speed;
			full_duplex_state_q       <= poll_res.full_duplex;
			partner_sends_pause_q     <= poll_res.sends_pause;
			partner_honours_pause_q   <= poll_res.honours_pause;
		end else if (pce && poll_noresp) begin
			// a silent phy cannot hold a link
			link_up_state_q <= 1'b0;
		end
	end

	// responding flag follows every poll outcome
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phy_responding_q <= 1'b0;
		end else if (pce) begin
			if (poll_upd) begin
				phy_responding_q <= 1'b1;
			end else if (poll_noresp) begin
				phy_responding_q <= 1'b0;
			end
		end
	end

	// configuration and override registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			poll_config_reg_q         <= `PPS_RST_CFG;
			port0_link_override_reg_q <= `PPS_RST_OVR;
			irq_en_q                  <= `PPS_RST_IRQ_EN;
		end else if (pce) begin
			if (wr_cfg) begin
				poll_config_reg_q <= pwdata[0];
			end
			if (wr_ovr) begin
				port0_link_override_reg_q <= pwdata[15:0];
			end
			if (wr_ien) begin
				irq_en_q <= pwdata[3:0];
			end
		end
	end

	// interrupt state and resolved link
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= 4'h0;
			irq_q      <= 1'b0;
			link_q     <= '0;
		end else if (pce) begin
			irq_stat_q <= irq_stat_d;
			irq_q      <= irq_d;
			link_q     <= link_d;
		end
	end

	assign prdata      = prdata_q;
	assign pready      = pready_q;
	assign pslverr     = pslverr_q;
	assign link_out    = link_q;
	// the address field is a flop of the override register
	assign phy_addr    = port0_link_override_reg_q[`PPS_OVR_ADDR_HI:0];
	assign autopoll_en = poll_config_reg_q;
	assign irq         = irq_q;

endmodule

// ==== test/pps_phy_model.sv ====
// behavioural polling engine, attached phy and mii lines
`timescale 1ns/100ps
module pps_phy_model
	import pps_pkg::*;
(
	input  wire logic    pclk,
	output pps_poll_res_t poll_res,
	output logic          poll_upd,
	output logic          poll_noresp,
	output logic          mii_rxdv,
	output logic          mii_txen
);
	initial begin
		{poll_upd, poll_noresp, mii_rxdv, mii_txen} = 4'h0;
		poll_res = 8'h00;
	end
	// result is only valid with the strobe; afterwards show the inverse
	task automatic poll(input pps_poll_res_t r);
		@(posedge pclk);
		poll_upd <= 1'b1;
		poll_res <= r;
		@(posedge pclk);
		poll_upd <= 1'b0;
		poll_res <= ~r;
	endtask
	task automatic noresp;
		@(posedge pclk);
		poll_noresp <= 1'b1;
		@(posedge pclk);
		poll_noresp <= 1'b0;
	endtask
	// hold long enough for the two-flop synchroniser, then let it settle
	task automatic traffic(input logic rx, input logic tx);
		@(posedge pclk);
		mii_rxdv <= rx;
		mii_txen <= tx;
		repeat (3) @(posedge pclk);
		mii_rxdv <= 1'b0;
		mii_txen <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask
endmodule

// ==== test/pps_poll_status_chk.sv ====
// port assertions of the phy poll status block
`timescale 1ns/100ps
module pps_chk
	import pps_pkg::*;
(
	input wire logic          pclk,
	input wire logic          presetn,
	input wire logic          pce,
	input wire logic          psel,
	input wire logic          penable,
	input wire logic          pwrite,
	input wire logic [11:0]   paddr,
	input wire logic [31:0]   pwdata,
	input wire logic [31:0]   prdata,
	input wire logic          pready,
	input wire logic          pslverr,
	input wire logic          poll_upd,
	input wire logic          poll_noresp,
	input wire pps_poll_res_t poll_res,
	input wire pps_link_t     link_out,
	input wire logic [4:0]    phy_addr,
	input wire logic          autopoll_en
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire       rd_st = pready && !pwrite && paddr == 12'h058;
	wire [4:0] wd5   = pwdata[4:0];
	wire [3:0] lsd   = poll_res[5:2];
	// a frozen slave may not answer, so only enabled cycles count
	property p_ans; psel && penable && !pready && pce |=> pready; endproperty
	a_ans: assert property (p_ans) else $error("no answer after access");
	property p_pulse; pready && pce |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
	property p_err; pready && pslverr |-> prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("error read not zero");
	property p_rsv; rd_st |-> prdata[31:11] == 21'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
	property p_poll;
		rd_st && $past(poll_upd, 2) && !$past(poll_upd) && !$past(poll_noresp)
			|-> prdata[6] && {prdata[8:7], prdata[5:0]} == $past(poll_res, 2);
	endproperty
	a_poll: assert property (p_poll) else $error("poll result not shown");
	property p_lost;
		rd_st && $past(poll_noresp, 2) && !$past(poll_upd, 2) && !$past(poll_upd)
			&& !$past(poll_noresp) |-> prdata[6:5] == 2'b00;
	endproperty
	a_lost: assert property (p_lost) else $error("silent phy still active");
	property p_addr; pready && pwrite && paddr == 12'h054 |=> phy_addr == $past(wd5); endproperty
	a_addr: assert property (p_addr) else $error("phy address not taken");
	property p_link;
		poll_upd && autopoll_en ##1 !poll_upd && !poll_noresp && autopoll_en
			|=> link_out[5:2] == $past(lsd, 2);
	endproperty
	a_link: assert property (p_link) else $error("link not from poll");
endmodule
bind pps_poll_status pps_chk u_chk (.pclk, .presetn, .pce, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .poll_upd, .poll_noresp, .poll_res, .link_out,
	.phy_addr, .autopoll_en);

// ==== test/phy_poll_status_register_bench.sv ====
// self-checking bench of the phy poll status block
`timescale 1ns/100ps
module phy_poll_status_register_bench;
	import pps_pkg::*;
	logic          pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0]   paddr = 12'h000;
	logic [31:0]   pwdata = 32'h0, prdata, rv;
	logic          pready, pslverr, irq, autopoll_en, re;
	logic          pce = 1'b1;
	logic          poll_upd, poll_noresp, mii_rxdv, mii_txen;
	pps_poll_res_t poll_res;
	pps_link_t     gphy_link = 6'h2A, link_out;
	logic [4:0]    phy_addr;
	int            error_cnt = 0, checks_done = 0, st = 0;
	always #25 pclk = ~pclk;
	pps_phy_model phy (.pclk, .poll_res, .poll_upd, .poll_noresp, .mii_rxdv, .mii_txen);
	pps_poll_status dut (.pclk, .presetn, .pce, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .poll_upd, .poll_noresp, .poll_res,
		.gphy_link, .mii_rxdv, .mii_txen, .link_out, .phy_addr, .autopoll_en, .irq);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && n++ < 50);
		// a missing answer counts as a mismatch
		if (pready !== 1'b1) error_cnt++;
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rv, e);
	endtask
	task automatic results;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#(50 * 4000);
		error_cnt++;
		results;
	end
	initial begin
		logic [7:0] r;
		void'($urandom(53));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h058, 32'h0);
		rd(12'h054, 32'h1800);
		rd(12'h040, 32'h1);
		rd(12'h064, 32'h0);
		rd(12'h07C, 32'h0);
		chk({31'h0, re}, 32'h1);
		// freeze the slave through the access phase; the answer must wait for the enable
		fork
			begin
				repeat (2) @(posedge pclk);
				pce <= 1'b0;
				repeat (3) @(posedge pclk);
				pce <= 1'b1;
			end
			rd(12'h040, 32'h1);
		join
		// every speed code, reserved included, with 00 and 01 twice; read races the poll on purpose
		for (int i = 0; i < 6; i++) begin
			r = 8'($urandom);
			r[4:3] = i[1:0];
			st = (st & 'h600) | {r[7:6], 1'b1, r[5:0]};
			fork phy.poll(r); rd(12'h058, st); join
			if (i == 3) begin
				st = st & 'h79F;
				fork phy.noresp(); rd(12'h058, st); join
			end
		end
		wr(12'h068, 32'hF);
		phy.traffic(1'b1, 1'b0);
		st = st | 'h400;
		rd(12'h058, st);
		wr(12'h058, 32'hFFFF_F9FF);
		rd(12'h058, st);
		phy.traffic(1'b0, 1'b1);
		st = st | 'h200;
		rd(12'h058, st);
		chk({31'h0, irq}, 32'h0);
		rd(12'h060, 32'h3);
		wr(12'h064, 32'h2);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		wr(12'h068, 32'h2);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		rd(12'h060, 32'h1);
		wr(12'h058, 32'h600);
		st = st & 'h1FF;
		rd(12'h058, st);
		wr(12'h040, 32'h0);
		r = 8'($urandom) & 8'h1F;
		wr(12'h054, 32'h32A0 | r);
		repeat (2) @(posedge pclk);
		chk({27'h0, phy_addr}, r);
		chk({26'h0, link_out}, 32'h37);
		rd(12'h06C, 32'h37);
		// every field automatic with the integrated phy as source
		wr(12'h054, 32'h9800);
		rd(12'h06C, 32'h2A);
		results;
	end
endmodule
